// [inc/mer_pkg.sv]
// package: shared constants and carriers for the modbus exception responder
package mer_pkg;

   // ***************************************************************
   // exception codes and frame constants
   // ***************************************************************
   localparam logic [7:0] MER_EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] MER_EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] MER_EXC_ILL_VALUE = 8'h03;
   localparam logic [7:0] MER_EXC_DEV_FAIL = 8'h04;
   localparam logic [7:0] MER_EXC_BUSY = 8'h06;
   localparam logic [7:0] MER_EXC_NAK = 8'h07;
   localparam logic [7:0] MER_EXC_OVERFLOW = 8'h09;
   localparam logic [7:0] MER_FC_FLAG = 8'h80;
   localparam logic [7:0] MER_FC_READ_FILE = 8'h14;
   localparam logic [15:0] MER_CRC_INIT = 16'hFFFF;
   localparam logic [15:0] MER_CRC_POLY = 16'hA001;
   localparam logic [2:0] MER_FRAME_LEN = 3'h5;
   localparam logic [2:0] MER_CRC_LO_IDX = 3'h3;

   // ***************************************************************
   // carriers
   // ***************************************************************
   // one received query, already framed and checked by the receiver
   typedef struct packed {
      logic [7:0] slave_addr;
      logic [7:0] func_code;
      logic crc_ok;
      logic parity_ok;
   } mer_query_s;

   // verdict from the serving logic about that query
   typedef struct packed {
      logic func_bad;
      logic addr_bad;
      logic value_bad;
      logic dev_fault;
      logic busy;
      logic nak;
      logic overflow;
   } mer_verdict_s;

   typedef enum logic [1:0] {
      MER_IDLE = 2'b00,
      MER_SEND = 2'b01,
      MER_WAIT = 2'b10
   } mer_state_e;

endpackage

// [src/mer_crc16.sv]
// crc-16 byte step used for the exception frame check
`timescale 1ns/100ps
`default_nettype none
module mer_crc16
   import mer_pkg::*;
(
   // running value
   input wire logic [15:0] crc_i,
   // byte folded in
   input wire logic [7:0] data_i,
   // updated value
   output logic [15:0] crc_o
);

   // ***************************************************************
   // bitwise reflected crc, one byte per call
   // ***************************************************************
   logic [15:0] stage [0:8];
   assign stage[0] = crc_i ^ {8'h00, data_i};
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_bit
         // shift right, fold polynomial when the dropped bit was set
         assign stage[g+1] = stage[g][0] ?
            ((stage[g] >> 1) ^ MER_CRC_POLY) : (stage[g] >> 1);
      end
   endgenerate
   assign crc_o = stage[8];

endmodule // mer_crc16
`default_nettype wire

// [src/mer_responder.sv]
// modbus rtu exception responder: classify and send exception frames
// How it works
// - reply address, function or 80h, code, crc
// - unpermitted function gives code 01
// - unknown register address gives code 02
// - out of range value gives code 03
// - internal fault gives code 04
// - busy refusal gives code 06
// - device specific refusal gives code 07
// - code 09 only for function 20 overflow
// - no reply to parity or crc errors
// - normal replies echo function code below 80h
`timescale 1ns/100ps
`default_nettype none
module mer_responder
   import mer_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // query from the receiver, one pulse per frame
   input wire logic query_valid_i,
   input wire mer_query_s query_i,
   input wire mer_verdict_s verdict_i,
   // byte stream to the transmitter
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o,
   // status
   output logic busy_o,
   output logic exc_sent_o,
   output logic [7:0] exc_code_o
);

   // ***************************************************************
   // state
   // ***************************************************************
   mer_state_e state, next_state;
   logic [7:0] addr, next_addr;
   logic [7:0] func, next_func;
   logic [7:0] code, next_code;
   logic [15:0] crc, next_crc;
   logic [2:0] idx, next_idx;
   logic tx_valid, next_tx_valid;
   logic [7:0] tx_data, next_tx_data;
   logic tx_last, next_tx_last;
   logic exc_sent, next_exc_sent;
   logic [7:0] exc_code, next_exc_code;
   logic [15:0] crc_step;
   logic [7:0] sel_code;
   logic exc_hit;
   logic [7:0] cur_byte;

   // crc runs over each byte just launched
   mer_crc16 u_crc (
      .crc_i(crc),
      .data_i(tx_data),
      .crc_o(crc_step)
   );

   // ***************************************************************
   // classification
   // ***************************************************************
   // priority picks the most basic fault first; overflow only for fc 20
   always_comb begin
      sel_code = 8'h00;
      exc_hit = 1'b1;
      if (verdict_i.func_bad) begin
         sel_code = MER_EXC_ILL_FUNC;
      end else if (verdict_i.addr_bad) begin
         sel_code = MER_EXC_ILL_ADDR;
      end else if (verdict_i.value_bad) begin
         sel_code = MER_EXC_ILL_VALUE;
      end else if (verdict_i.dev_fault) begin
         sel_code = MER_EXC_DEV_FAIL;
      end else if (verdict_i.busy) begin
         sel_code = MER_EXC_BUSY;
      end else if (verdict_i.nak) begin
         sel_code = MER_EXC_NAK;
      end else if (verdict_i.overflow &&
                   query_i.func_code == MER_FC_READ_FILE) begin
         sel_code = MER_EXC_OVERFLOW;
      end else begin
         exc_hit = 1'b0; // normal reply made elsewhere
      end
   end

   // next header byte to launch after the one now on the bus
   always_comb begin
      case (idx)
         3'h0: cur_byte = func;
         3'h1: cur_byte = code;
         default: cur_byte = addr;
      endcase
   end

   // ***************************************************************
   // frame sequencer
   // ***************************************************************
   always_comb begin
      next_state = state;
      next_addr = addr;
      next_func = func;
      next_code = code;
      next_crc = crc;
      next_idx = idx;
      next_tx_valid = tx_valid;
      next_tx_data = tx_data;
      next_tx_last = tx_last;
      next_exc_sent = 1'b0;
      next_exc_code = exc_code;
      case (state)
         MER_IDLE: begin
            // corrupt frames are dropped silently
            if (query_valid_i && query_i.crc_ok && query_i.parity_ok &&
                exc_hit) begin
               next_addr = query_i.slave_addr;
               next_func = query_i.func_code | MER_FC_FLAG;
               next_code = sel_code;
               next_exc_code = sel_code;
               next_crc = MER_CRC_INIT;
               next_idx = 3'h0;
               next_tx_data = query_i.slave_addr;
               next_tx_valid = 1'b1;
               next_tx_last = 1'b0;
               next_state = MER_SEND;
            end
         end
         MER_SEND: begin
            if (tx_ready_i) begin
               next_idx = idx + 3'h1;
               if (idx < 3'h2) begin
                  next_crc = crc_step;
                  next_tx_data = cur_byte;
               end else if (idx == 3'h2) begin
                  next_crc = crc_step;
                  next_tx_data = crc_step[7:0]; // low first
               end else if (idx == MER_CRC_LO_IDX) begin
                  next_tx_data = crc[15:8];
                  next_tx_last = 1'b1;
               end else begin
                  next_tx_valid = 1'b0;
                  next_tx_last = 1'b0;
                  next_exc_sent = 1'b1;
                  next_state = MER_IDLE;
               end
            end
         end
         default: begin
            next_state = MER_IDLE;
            next_tx_valid = 1'b0;
         end
      endcase
   end

   // register everything
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= MER_IDLE;
         addr <= 8'h00;
         func <= 8'h00;
         code <= 8'h00;
         crc <= MER_CRC_INIT;
         idx <= 3'h0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_last <= 1'b0;
         exc_sent <= 1'b0;
         exc_code <= 8'h00;
      end else begin
         state <= next_state;
         addr <= next_addr;
         func <= next_func;
         code <= next_code;
         crc <= next_crc;
         idx <= next_idx;
         tx_valid <= next_tx_valid;
         tx_data <= next_tx_data;
         tx_last <= next_tx_last;
         exc_sent <= next_exc_sent;
         exc_code <= next_exc_code;
      end
   end

   // busy flag registered so it stays a flop output
   logic busy;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy <= 1'b0;
      end else begin
         busy <= (next_state != MER_IDLE);
      end
   end

   assign tx_valid_o = tx_valid;
   assign tx_data_o = tx_data;
   assign tx_last_o = tx_last;
   assign busy_o = busy;
   assign exc_sent_o = exc_sent;
   assign exc_code_o = exc_code;

endmodule // mer_responder
`default_nettype wire

// [testbench/mer_master_model.sv]
// far-side transmitter and master model collecting exception frames
`timescale 1ns/100ps
`default_nettype none
module mer_master_model (
   // clock, reset and pacing
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic slow_i,
   // byte stream from the responder
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_last_i,
   output logic tx_ready_o,
   // last five bytes and number of frames seen
   output logic [39:0] frame_o,
   output logic [7:0] n_frames_o
);
   logic stall;
   // slow mode stalls every other cycle to test byte holding
   assign tx_ready_o = !(slow_i && stall);
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stall <= 1'b0;
         frame_o <= 40'h0;
         n_frames_o <= 8'h00;
      end else begin
         stall <= !stall;
         if (tx_valid_i && tx_ready_o) begin
            frame_o <= {frame_o[31:0], tx_data_i};
            if (tx_last_i) n_frames_o <= n_frames_o + 8'h01;
         end
      end
   end
endmodule // mer_master_model
`default_nettype wire

// [testbench/mer_responder_assertions.sv]
// checker of the exception responder's byte stream and status
`timescale 1ns/100ps
`default_nettype none
module mer_responder_chk
   import mer_pkg::*;
(
   // watched ports of the responder
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic query_valid_i,
   input wire mer_query_s query_i,
   input wire mer_verdict_s verdict_i,
   input wire logic tx_ready_i,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_last_o,
   input wire logic busy_o,
   input wire logic exc_sent_o,
   input wire logic [7:0] exc_code_o
);
   logic take;
   logic idle;
   logic [2:0] idx;
   logic [7:0] fc_q;
   logic [7:0] code_q;
   // idle excludes the exc_sent cycle, whose acceptance is left open
   assign idle = query_valid_i && !busy_o && !tx_valid_o && !exc_sent_o;
   assign take = idle && query_i.crc_ok && query_i.parity_ok
      && ((|verdict_i[6:1]) || (verdict_i.overflow
      && query_i.func_code == MER_FC_READ_FILE));
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // byte index of the frame, function and code captured for later
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx <= 3'h0;
         fc_q <= 8'h00;
         code_q <= 8'h00;
      end else begin
         if (take) fc_q <= query_i.func_code;
         if (tx_valid_o && idx == 3'h2) code_q <= tx_data_o;
         if (tx_valid_o && tx_ready_i) idx <= tx_last_o ? 3'h0 : idx + 3'h1;
      end
   end
   start_addr_a: assert property (take |=> tx_valid_o && busy_o
      && tx_data_o == $past(query_i.slave_addr)) else $error("bad start");
   no_cause_a: assert property (idle && !take |=> !tx_valid_o)
      else $error("reply without cause");
   hold_byte_a: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o)) else $error("byte not held");
   func_flag_a: assert property (tx_valid_o && idx == 3'h1 |->
      tx_data_o == (fc_q | MER_FC_FLAG)) else $error("bad function");
   overflow_only_a: assert property (tx_valid_o && idx == 3'h2
      && tx_data_o == MER_EXC_OVERFLOW |-> fc_q == MER_FC_READ_FILE)
      else $error("overflow code misused");
   last_byte_a: assert property (tx_valid_o |->
      tx_last_o == (idx == 3'h4)) else $error("bad last flag");
   sent_pulse_a: assert property (tx_valid_o && tx_last_o
      && tx_ready_i |=> exc_sent_o && !tx_valid_o && !busy_o
      ##1 !exc_sent_o) else $error("bad end of frame");
   code_report_a: assert property (exc_sent_o |->
      exc_code_o == code_q) else $error("bad code report");
endmodule // mer_responder_chk
bind mer_responder mer_responder_chk chk (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .query_valid_i(query_valid_i),
   .query_i(query_i), .verdict_i(verdict_i), .tx_ready_i(tx_ready_i),
   .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
   .busy_o(busy_o), .exc_sent_o(exc_sent_o), .exc_code_o(exc_code_o));
`default_nettype wire

// [testbench/tb_top.sv]
// testbench for the modbus exception responder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mer_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic query_valid_i = 1'b0;
   logic slow = 1'b0;
   mer_query_s query_i = '0;
   mer_verdict_s verdict_i = '0;
   logic tx_ready_i, tx_valid_o, tx_last_o, busy_o, exc_sent_o;
   logic [7:0] tx_data_o, exc_code_o, n_frames;
   logic [39:0] frame;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   always #12.5 clk_i = ~clk_i;
   mer_responder dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .query_valid_i(query_valid_i), .query_i(query_i),
      .verdict_i(verdict_i), .tx_ready_i(tx_ready_i),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
      .tx_last_o(tx_last_o), .busy_o(busy_o), .exc_sent_o(exc_sent_o),
      .exc_code_o(exc_code_o));
   mer_master_model partner (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .frame_o(frame),
      .n_frames_o(n_frames));
   // hang guard: all tests need well under this many cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails = fails + 1;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [39:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // reflected crc over address, function and code
   function automatic logic [15:0] crc3(input logic [23:0] d);
      logic [15:0] c;
      c = MER_CRC_INIT;
      for (int i = 2; i >= 0; i--) begin
         c = c ^ {8'h00, d[i*8 +: 8]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? (c >> 1) ^ MER_CRC_POLY : c >> 1;
         end
      end
      return c;
   endfunction
   // one query pulse from slave 02, then a frame or silence
   task automatic go(input logic [7:0] fc, input logic [6:0] v,
      input logic [1:0] ok, input logic [7:0] code);
      logic [7:0] n0;
      logic [15:0] c;
      n0 = n_frames;
      c = crc3({8'h02, fc | MER_FC_FLAG, code});
      @(posedge clk_i);
      query_valid_i <= 1'b1;
      query_i <= {8'h02, fc, ok};
      verdict_i <= v;
      @(posedge clk_i);
      query_valid_i <= 1'b0;
      for (int i = 0; i < 40 && n_frames == n0; i++) @(posedge clk_i);
      @(posedge clk_i);
      if (code == 8'h00) begin
         chk("silence", {32'h0, n_frames}, {32'h0, n0});
      end else begin
         chk("frame", frame, {8'h02, fc | MER_FC_FLAG, code, c[7:0],
            c[15:8]});
         chk("code", {32'h0, exc_code_o}, {32'h0, code});
      end
   endtask
   // every verdict alone, alternating pacing, then all at once
   task automatic t_codes;
      logic [7:0] codes [7] = '{8'h09, 8'h07, 8'h06, 8'h04, 8'h03,
         8'h02, 8'h01};
      for (int i = 0; i < 7; i++) begin
         slow <= i[0];
         go(i == 0 ? MER_FC_READ_FILE : 8'h03, 7'h01 << i, 2'b11,
            codes[i]);
      end
      go(8'h03, 7'h7F, 2'b11, MER_EXC_ILL_FUNC);
      // follow-up poll after an illegal function reply is served by the normal path: silence
      go(8'h03, 7'h00, 2'b11, 8'h00);
      $display("test codes done");
   endtask
   // bad check, bad parity, overflow off function 20, no cause
   task automatic t_quiet;
      go(8'h03, 7'h08, 2'b01, 8'h00);
      go(8'h03, 7'h08, 2'b10, 8'h00);
      go(8'h03, 7'h01, 2'b11, 8'h00);
      go(8'h03, 7'h00, 2'b11, 8'h00);
      $display("test quiet done");
   endtask
   // a second query while a frame is out must be ignored
   task automatic t_busy;
      logic [7:0] n0;
      n0 = n_frames;
      @(posedge clk_i);
      query_valid_i <= 1'b1;
      query_i <= {8'h05, 8'h03, 2'b11};
      verdict_i <= 7'h08;
      repeat (2) @(posedge clk_i);
      verdict_i <= 7'h40;
      @(posedge clk_i);
      query_valid_i <= 1'b0;
      repeat (30) @(posedge clk_i);
      chk("one frame", {32'h0, n_frames}, {32'h0, n0 + 8'h01});
      chk("code", {32'h0, exc_code_o},
         {32'h0, MER_EXC_DEV_FAIL});
      $display("test busy done");
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_codes();
      t_quiet();
      t_busy();
      close_out();
   end
endmodule // tb_top
`default_nettype wire
